/* File: common/dxg_pkg.sv */
// Purpose: shared constants and types for the x2 gearing memory datapath
// Assumes: one core clock acting as the fast edge clock
// Notes: register offsets are byte addresses on a 32-bit APB
package dxg_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RDCTL_OFS = 8'h04;
    localparam logic [7:0] WLDLY_OFS = 8'h08;
    localparam logic [7:0] PAUSE_OFS = 8'h0C;
    localparam logic [7:0] CMD_OFS = 8'h10;
    localparam logic [7:0] WDATA_OFS = 8'h14;
    localparam logic [7:0] RDATA_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1C;
    // field positions
    localparam int MODE_LSB = 0;
    localparam int LOADN_BIT = 2;
    localparam int MOVE_BIT = 3;
    localparam int DIR_BIT = 4;
    localparam int WIN_LSB = 0;
    localparam int PSEL_LSB = 2;
    localparam int UPAUSE_BIT = 0;
    localparam int CAPAUSE_BIT = 1;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    localparam logic [22:0] CMD_RST = 23'h00_003F;
    // gearing counts
    localparam int GEAR_RATIO = 4;
    localparam int CLK_DIV = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int DLY_TAPS = 8;
    typedef enum logic [1:0] {MODE_DDR3, MODE_LPDDR2, MODE_LPDDR4, MODE_RSVD} dxg_mode_e;
    typedef enum {WR_IDLE, WR_WAIT, WR_RUN} dxg_wrst_e;
    // command word as held in the command register
    typedef struct packed {
        logic [13:0] addr;
        logic [2:0] ba;
        logic rasN;
        logic casN;
        logic weN;
        logic cke;
        logic odt;
        logic csN;
    } dxg_cmd_s;
endpackage

/* File: src/dxg_phy_datapath.sv */
// Purpose: x2 gearing DDR3 / LPDDR2 / LPDDR4 physical datapath
// Assumes: core_clk is the fast edge clock; pins sampled synchronously
// Notes: each ...Pair pin output is a {second, first} pair per edge clock cycle; cmdOut and the enables are single
//
// Overview of operation
// - gearboxes serialise and deserialise four to one
// - system clock is edge clock halved
// - delay code shifts read strobe for capture
// - strobe buffer drives capture fifo write pointer
// - leveling feedback output for DDR3 and LPDDR4
// - synchronizer pause path always present
// - margin controls exist only when option set
// - data on 270 clock, strobe 90 later
// - leveling delay shared by both write clocks
// - own tristate per DQ, separate for DQS
// - DDR3 memory clock from constant gearbox inputs
// - DDR3 commands via 2:1, CSN via shift
// - LPDDR uses CA and control strobe buffers
// - CA ten bits LPDDR2, six LPDDR4
// - LPDDR CSN paired per memory clock, CKE single bit
// - LPDDR clock inputs alternate zero and one
// - LPDDR ODT only on LPDDR4, single bit
// - capture fifo eight deep, three-bit pointers
`timescale 1ns/1ns
module dxg_phy_datapath #(
    parameter int DQ_W = 8,
    parameter bit MARGIN_EN = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] dllCode,
    input wire logic syncPauseReq,
    input wire logic incomingReadStrobe,
    input wire logic [DQ_W-1:0] dqIn,
    output logic levelingFeedbackOut,
    output logic [1:0][DQ_W-1:0] dqPair,
    output logic [1:0] dmPair,
    output logic [DQ_W-1:0] dqOe_n,
    output logic [1:0] dqsPair,
    output logic dqsOe_n,
    output logic [1:0] memClkPair,
    output logic [1:0] csnPair,
    output dxg_pkg::dxg_cmd_s cmdOut,
    output logic [1:0][9:0] caPair,
    output logic strobePause,
    output logic caPause
);
    import dxg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [31:0] ctrl_reg, rdCtl_reg, wlDly_reg, pause_reg, wdata_reg, rdWord_reg;
    dxg_cmd_s cmd_reg;
    logic sclkPhase_reg;
    logic [4:0] rdActive_reg;
    logic [7:0] wlActive_reg, margin_reg;
    logic [3:0] strobeSr_reg;
    logic capPrev_reg, rdValid_reg;
    logic [DQ_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_reg, rdPtr_reg;
    logic [7:0] gateSr_reg;
    logic [1:0] beatCnt_reg;
    logic [31:0] rdShift_reg;
    dxg_wrst_e wrState_reg;
    logic wrGo_reg, cmdGo_reg, cmdLaunch_reg;
    logic [DLY_TAPS-1:0][2*DQ_W+2:0] wrDly_reg;
    logic [2*DQ_W+2:0] launchNow;
    logic [2*DQ_W+2:0] launched;
    logic [7:0] effCode;
    logic capStrobe, capEdge, gateNow, fifoEmpty, wrAccess, rdSetup;
    dxg_mode_e mode;

    // first half of a system cycle carries beats 0/1, second half 2/3
    function automatic logic [1:0] pick_pair(input logic [3:0] beats, input logic ph);
        pick_pair = ph ? beats[3:2] : beats[1:0];
    endfunction

    assign mode = dxg_mode_e'(ctrl_reg[MODE_LSB +: 2]);
    assign wrAccess = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // halved system clock phase; the gearboxes key off it
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sclkPhase_reg <= 1'b0;
        else
            sclkPhase_reg <= ~sclkPhase_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, error on unmapped word
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable && (paddr[1:0] != 2'b00 || paddr > STAT_OFS))
            pslverr = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RST;
            rdCtl_reg <= ZERO_RST;
            wlDly_reg <= ZERO_RST;
            pause_reg <= ZERO_RST;
            wdata_reg <= ZERO_RST;
            cmd_reg <= CMD_RST;
        end
        else if (wrAccess)
        begin
            case (paddr)
                CTRL_OFS: ctrl_reg <= pwdata;
                RDCTL_OFS: rdCtl_reg <= pwdata;
                WLDLY_OFS: wlDly_reg <= pwdata;
                PAUSE_OFS: pause_reg <= pwdata;
                CMD_OFS: cmd_reg <= dxg_cmd_s'(pwdata[22:0]);
                WDATA_OFS: wdata_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // launch requests from data and command writes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wrGo_reg <= 1'b0;
            cmdGo_reg <= 1'b0;
        end
        else
        begin
            wrGo_reg <= wrAccess && paddr == WDATA_OFS;
            cmdGo_reg <= (wrAccess && paddr == CMD_OFS) || (cmdGo_reg && sclkPhase_reg);
        end
    end

    // read data is captured in setup so it stands through the access phase
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata <= ZERO_RST;
        else if (rdSetup)
        begin
            case (paddr)
                CTRL_OFS: prdata <= MARGIN_EN ? ctrl_reg : {ctrl_reg[31:2] & 30'h0, ctrl_reg[1:0]};
                RDCTL_OFS: prdata <= rdCtl_reg;
                WLDLY_OFS: prdata <= wlDly_reg;
                PAUSE_OFS: prdata <= pause_reg;
                CMD_OFS: prdata <= {9'h000, cmd_reg};
                WDATA_OFS: prdata <= wdata_reg;
                RDATA_OFS: prdata <= rdWord_reg;
                STAT_OFS: prdata <= {8'h00, effCode, 2'h0, wrPtr_reg, rdPtr_reg,
                    3'h0, wrState_reg != WR_IDLE, rdValid_reg, caPause, strobePause,
                    levelingFeedbackOut};
                default: prdata <= ZERO_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pause combining; synchronizer request always wired in
    assign strobePause = syncPauseReq | pause_reg[UPAUSE_BIT];
    assign caPause = syncPauseReq | pause_reg[CAPAUSE_BIT];

    // trained settings move to the strobe buffer only under pause,
    // so a change never lands on a live strobe
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdActive_reg <= 5'h00;
            wlActive_reg <= 8'h00;
        end
        else if (strobePause)
        begin
            rdActive_reg <= rdCtl_reg[4:0];
            wlActive_reg <= wlDly_reg[7:0];
        end
    end

    // margin offset stepping, absent when the option is off
    always_ff @(posedge core_clk)
    begin
        if (rst || !MARGIN_EN)
            margin_reg <= 8'h00;
        else if (!ctrl_reg[LOADN_BIT])
            margin_reg <= dllCode;
        else if (strobePause && ctrl_reg[MOVE_BIT])
            margin_reg <= ctrl_reg[DIR_BIT] ? margin_reg - 8'h01 : margin_reg + 8'h01;
    end

    assign effCode = (MARGIN_EN && ctrl_reg[LOADN_BIT]) ? margin_reg : dllCode;

    ////////////////////////////////////////////////////////////////////////
    // read strobe delay line; top code bits choose the quarter-period tap
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            strobeSr_reg <= 4'h0;
            capPrev_reg <= 1'b0;
        end
        else
        begin
            strobeSr_reg <= {strobeSr_reg[2:0], incomingReadStrobe};
            capPrev_reg <= capStrobe;
        end
    end

    assign capStrobe = strobeSr_reg[effCode[7:6]];
    assign capEdge = capStrobe && !capPrev_reg;

    // read window bits become a gate, shifted by the phase select
    always_ff @(posedge core_clk)
    begin
        if (rst)
            gateSr_reg <= 8'h00;
        else
            gateSr_reg <= {gateSr_reg[6:0],
                sclkPhase_reg ? rdActive_reg[WIN_LSB + 1] : rdActive_reg[WIN_LSB]};
    end

    assign gateNow = gateSr_reg[rdActive_reg[PSEL_LSB +: 3]];

    // capture fifo; strobe buffer owns the write pointer, edge side the read pointer
    always_ff @(posedge core_clk)
    begin
        if (capEdge && gateNow)
            fifo_mem[wrPtr_reg] <= dqIn;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            wrPtr_reg <= '0;
        else if (capEdge && gateNow && !strobePause)
            wrPtr_reg <= wrPtr_reg + 3'd1;
    end

    assign fifoEmpty = wrPtr_reg == rdPtr_reg;

    // edge side drains the fifo and assembles one word per four beats
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdPtr_reg <= '0;
            beatCnt_reg <= 2'd0;
            rdShift_reg <= ZERO_RST;
            rdWord_reg <= ZERO_RST;
            rdValid_reg <= 1'b0;
        end
        else if (!fifoEmpty)
        begin
            rdPtr_reg <= rdPtr_reg + 3'd1;
            beatCnt_reg <= beatCnt_reg + 2'd1;
            rdShift_reg <= {rdShift_reg[23:0], 8'(fifo_mem[rdPtr_reg])};
            if (beatCnt_reg == 2'd3)
            begin
                rdWord_reg <= {rdShift_reg[23:0], 8'(fifo_mem[rdPtr_reg])};
                rdValid_reg <= 1'b1;
            end
        end
        else if (rdSetup && paddr == RDATA_OFS)
            rdValid_reg <= 1'b0;
    end

    // leveling feedback sampled on the delayed strobe edge
    always_ff @(posedge core_clk)
    begin
        if (rst)
            levelingFeedbackOut <= 1'b0;
        else if (mode == MODE_LPDDR2)
            levelingFeedbackOut <= 1'b0;
        else if (capEdge)
            levelingFeedbackOut <= dqIn[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // write burst waits for a system cycle boundary, then spans one cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wrState_reg <= WR_IDLE;
        else
        begin
            case (wrState_reg)
                WR_IDLE: if (wrGo_reg) wrState_reg <= WR_WAIT;
                // leave on the last half so the run opens with beats 0/1
                WR_WAIT: if (sclkPhase_reg) wrState_reg <= WR_RUN;
                WR_RUN: if (sclkPhase_reg) wrState_reg <= WR_IDLE;
                default: wrState_reg <= WR_IDLE;
            endcase
        end
    end

    // per lane beats: byte n of the word is beat n of the burst
    always_comb
    begin
        launchNow = '0;
        launchNow[2*DQ_W+2] = wrState_reg == WR_RUN;
        for (int i = 0; i < DQ_W; i++)
        begin
            launchNow[i] = wdata_reg[(sclkPhase_reg ? 16 : 0) + i];
            launchNow[DQ_W + i] = wdata_reg[(sclkPhase_reg ? 24 : 8) + i];
        end
        launchNow[2*DQ_W +: 2] = pick_pair(4'b1010, sclkPhase_reg);
        if (wrState_reg != WR_RUN)
            launchNow[2*DQ_W-1:0] = '0;
    end

    // one delay line feeds both write clocks so dq and dqs stay locked
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wrDly_reg <= '0;
        else
            wrDly_reg <= {wrDly_reg[DLY_TAPS-2:0], launchNow};
    end

    assign launched = wlActive_reg[2:0] == 3'd0 ? launchNow
        : wrDly_reg[wlActive_reg[2:0] - 3'd1];

    // data on the 270 clock; strobe launched a quarter later
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            dqPair <= '0;
            dmPair <= 2'b00;
            dqOe_n <= '1;
            dqsPair <= 2'b00;
            dqsOe_n <= 1'b1;
        end
        else
        begin
            dqPair <= {launched[DQ_W +: DQ_W], launched[0 +: DQ_W]};
            dmPair <= 2'b00;
            dqOe_n <= {DQ_W{!launched[2*DQ_W+2]}};
            dqsPair <= launched[2*DQ_W+2] ? launched[2*DQ_W +: 2] : 2'b00;
            dqsOe_n <= !launched[2*DQ_W+2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command launch aligned to a system cycle, pulsed for one edge cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cmdLaunch_reg <= 1'b0;
        else
            cmdLaunch_reg <= cmdGo_reg && !sclkPhase_reg;
    end

    // address, command and clock outputs per memory family
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cmdOut <= CMD_RST;
            csnPair <= 2'b11;
            memClkPair <= 2'b00;
            caPair <= '0;
        end
        else if (mode == MODE_DDR3)
        begin
            memClkPair <= pick_pair(4'b1010, sclkPhase_reg);
            cmdOut <= cmd_reg;
            csnPair <= cmdLaunch_reg ? {1'b1, cmd_reg.csN} : 2'b11;
            caPair <= '0;
        end
        else
        begin
            if (!strobePause)
            begin
                memClkPair <= pick_pair(4'b1010, sclkPhase_reg);
                cmdOut.cke <= cmd_reg.cke;
                cmdOut.odt <= mode == MODE_LPDDR4 ? cmd_reg.odt : 1'b0;
                csnPair <= {2{cmdLaunch_reg ? cmd_reg.csN : 1'b1}};
            end
            if (!caPause)
                caPair <= {2{mode == MODE_LPDDR4 ? {4'h0, cmd_reg.addr[5:0]}
                    : cmd_reg.addr[9:0]}};
        end
    end
endmodule // dxg_phy_datapath

/* File: tb/dxg_mem_model.sv */
// Purpose: memory device answering a read with a four-beat strobe burst
// Assumes: one byte lane, strobe runs only inside a burst
// Notes: released lane toggles, showing the last byte and its inverse in turn
`timescale 1ns/1ns
module dxg_mem_model (
    input wire logic core_clk,
    input wire logic start,
    input wire logic [31:0] burst,
    output logic readStrobe,
    output logic [7:0] dq
);
logic [3:0] cnt = 4'h0;
logic [31:0] sh = 32'h0000_0000;
initial readStrobe = 1'b0;
initial dq = 8'h00;
////////////////////////////////////////////////////////////////
// first byte sent first; strobe high then low per beat
always @(posedge core_clk)
begin
    if (start)
    begin
        cnt <= 4'h8;
        sh <= burst;
    end
    else if (cnt != 4'h0)
    begin
        readStrobe <= ~cnt[0];
        dq <= sh[31:24];
        if (cnt[0])
            sh <= sh << 8;
        cnt <= cnt - 4'h1;
    end
    else
    begin
        // strobe stands still, lane toggles so a stale sample shows
        readStrobe <= 1'b0;
        dq <= ~dq;
    end
end
endmodule // dxg_mem_model

/* File: tb/dxg_sva.sv */
// Purpose: port-level checks for the x2 gearing datapath
// Assumes: zero wait APB, one clock domain
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
module dxg_chk #(
    parameter int DQ_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic syncPauseReq,
    input wire logic strobePause,
    input wire logic caPause,
    input wire logic [1:0] dmPair,
    input wire logic [DQ_W-1:0] dqOe_n,
    input wire logic dqsOe_n,
    input wire logic [1:0] memClkPair,
    input wire logic [1:0][9:0] caPair
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////
// bus answer
chk_ready_now: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
chk_err_unmapped: assert property (psel && penable && (paddr > 8'h1C || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("bad address not refused");
chk_ok_mapped: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("good address refused");
////////////////////////////////////////////////////////////////
// pause combining, the sync request must always get through
chk_sync_pause: assert property (syncPauseReq |-> strobePause)
    else $error("strobe pause missed sync request");
chk_ca_sync: assert property (syncPauseReq |-> caPause)
    else $error("ca pause missed sync request");
////////////////////////////////////////////////////////////////
// pin patterns
chk_dm_low: assert property (dmPair == 2'b00)
    else $error("data mask driven");
chk_memclk_alt: assert property ($past(rst) == 1'b0 |-> memClkPair == 2'b10)
    else $error("memory clock pattern wrong");
chk_ca_halves: assert property (caPair[0] == caPair[1])
    else $error("ca halves differ");
chk_dq_oe_span: assert property ($fell(dqOe_n[0]) |-> ##1 !dqOe_n[0] ##1 dqOe_n[0])
    else $error("dq enable span wrong");
chk_dqs_oe_span: assert property ($fell(dqsOe_n) |-> ##1 !dqsOe_n ##1 dqsOe_n)
    else $error("dqs enable span wrong");
cover property ($fell(dqOe_n[0]));
cover property (psel && penable && pslverr);
cover property (syncPauseReq && strobePause && caPause);
endmodule // dxg_chk
bind dxg_phy_datapath dxg_chk #(.DQ_W(DQ_W)) dxg_chk_i (
    .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .syncPauseReq(syncPauseReq),
    .strobePause(strobePause), .caPause(caPause), .dmPair(dmPair), .dqOe_n(dqOe_n),
    .dqsOe_n(dqsOe_n), .memClkPair(memClkPair), .caPair(caPair));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the x2 gearing datapath
// Assumes: zero wait APB, DQ_W of 8
// Notes: pin outputs judged at the falling edge outside t_read, bus read data at the rising edge; inputs moved on the rising edge
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module tb_top;
import dxg_pkg::*;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic [7:0] paddr = 8'h00;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [31:0] pwdata = 32'h0000_0000;
logic [7:0] dllCode = 8'h00;
logic syncPauseReq = 1'b0;
logic start = 1'b0;
logic [31:0] burst = 32'h0000_0000;
logic incomingReadStrobe;
logic [7:0] dqIn;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic levelingFeedbackOut;
logic [1:0][7:0] dqPair;
logic [1:0] dmPair;
logic [7:0] dqOe_n;
logic [1:0] dqsPair;
logic dqsOe_n;
logic [1:0] memClkPair;
logic [1:0] csnPair;
dxg_cmd_s cmdOut;
logic [1:0][9:0] caPair;
logic strobePause;
logic caPause;
logic [31:0] rd;
logic err;
int bad_count = 0;
int tests_run = 0;
always #5 core_clk = ~core_clk;
dxg_phy_datapath #(.DQ_W(8), .MARGIN_EN(1'b1)) dxg_phy_datapath_i (
    .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dllCode(dllCode), .syncPauseReq(syncPauseReq),
    .incomingReadStrobe(incomingReadStrobe), .dqIn(dqIn),
    .levelingFeedbackOut(levelingFeedbackOut), .dqPair(dqPair), .dmPair(dmPair),
    .dqOe_n(dqOe_n), .dqsPair(dqsPair), .dqsOe_n(dqsOe_n), .memClkPair(memClkPair),
    .csnPair(csnPair), .cmdOut(cmdOut), .caPair(caPair), .strobePause(strobePause),
    .caPause(caPause));
dxg_mem_model dxg_mem_model_i (.core_clk(core_clk), .start(start), .burst(burst),
    .readStrobe(incomingReadStrobe), .dq(dqIn));
////////////////////////////////////////////////////////////////
// one APB transfer, held until ready is seen at a rising edge
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
        @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic results;
    if (bad_count == 0 && tests_run > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////
// scenarios
task automatic t_reset;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, CTRL_RST)
    apb(1'b0, WLDLY_OFS, 32'h0);
    `CHK(rd, ZERO_RST)
    @(negedge core_clk);
    `CHK(cmdOut, dxg_cmd_s'(CMD_RST))
    `CHK(dqOe_n, 8'hFF)
endtask
task automatic t_pause;
    for (int i = 0; i < 8; i++)
    begin
        @(posedge core_clk);
        syncPauseReq <= i[2];
        apb(1'b1, PAUSE_OFS, {30'h0, i[1:0]});
        @(negedge core_clk);
        `CHK(strobePause, i[2] | i[0])
        `CHK(caPause, i[2] | i[1])
    end
    @(posedge core_clk);
    syncPauseReq <= 1'b0;
    apb(1'b1, PAUSE_OFS, 32'h0);
endtask
task automatic t_err;
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 8'h06, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
endtask
task automatic t_burst;
    apb(1'b1, WLDLY_OFS, 32'h0);
    apb(1'b1, WDATA_OFS, 32'h4433_2211);
    for (int n = 0; n < 30 && dqOe_n !== 8'h00; n++)
        @(negedge core_clk);
    `CHK(dqPair[0], 8'h11)
    `CHK(dqPair[1], 8'h22)
    `CHK(dqsPair, 2'b10)
    `CHK(dqsOe_n, 1'b0)
    @(negedge core_clk);
    `CHK({dqPair[1], dqPair[0]}, 16'h4433)
    `CHK(dqsPair, 2'b10)
    @(negedge core_clk);
    `CHK(dqOe_n, 8'hFF)
endtask
task automatic t_cmd;
    apb(1'b1, CMD_OFS, 32'h002A_D5E0);
    repeat (2) @(negedge core_clk);
    `CHK(cmdOut, dxg_cmd_s'(23'h2A_D5E0))
    // chip select low for one edge cycle, only in the first half
    for (int n = 0; n < 6 && csnPair === 2'b11; n++)
        @(negedge core_clk);
    `CHK(csnPair, 2'b10)
    @(negedge core_clk);
    `CHK(csnPair, 2'b11)
endtask
// read settings only move under a pause held eight edge cycles either side of the settings write
task automatic t_read(input logic [1:0] mode, input logic fb, input logic [9:0] ca);
    apb(1'b1, CTRL_OFS, {30'h1, mode});
    apb(1'b1, PAUSE_OFS, 32'h1);
    repeat (8) @(posedge core_clk);
    apb(1'b1, RDCTL_OFS, 32'h3);
    repeat (8) @(posedge core_clk);
    apb(1'b1, PAUSE_OFS, 32'h0);
    burst <= 32'h8183_8587;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    rd = 32'h0;
    for (int n = 0; n < 20 && rd[3] !== 1'b1; n++)
        apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rd[3], 1'b1)
    apb(1'b0, RDATA_OFS, 32'h0);
    `CHK(rd, 32'h8183_8587)
    `CHK(levelingFeedbackOut, fb)
    `CHK(caPair[0], ca)
endtask
////////////////////////////////////////////////////////////////
// main sequence and watchdog
initial
begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_pause();
    t_err();
    t_burst();
    t_cmd();
    t_read(2'b00, 1'b1, 10'h000);
    t_read(2'b01, 1'b0, 10'h16A);
    t_read(2'b10, 1'b1, 10'h02A);
    results();
end
initial
begin
    #200000;
    bad_count++;
    results();
end
endmodule // tb_top
